// *** cpm_map.svh ***
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// memory mapped registers tied to address generation
`define CPM_OFS_POINTED_DATA   8'h0e
`define CPM_OFS_POINTER        8'h0f
`define CPM_OFS_PAGE_SELECT    8'h1f

// reset values
`define CPM_RST_ACC            8'h00
`define CPM_RST_PC             14'h3ffd
`define CPM_RST_SHADOW         14'h3ffd
`define CPM_RST_FLAG           1'b0
`define CPM_RST_POINTER        8'h00
`define CPM_RST_PAGE           8'h00

// page window bounds and layout
`define CPM_WIN_LO             14'h00c0
`define CPM_WIN_HI             14'h00ff
`define CPM_WIN_OFS_W          6
`define CPM_DIRECT_HI_ZERO     6'h00

// flag register bit positions
`define CPM_FLAG_C             0
`define CPM_FLAG_Z             1

// operand sign bit and the zero and one byte constants
`define CPM_SIGN_BIT           7
`define CPM_ZERO_BYTE          8'h00
`define CPM_ONE_BYTE           8'h01

`endif

// *** cpm_pkg.sv ***
package cpm_pkg;

	typedef enum logic [4:0] {
		CPM_OP_NOP        = 5'b00000,
		CPM_OP_LOAD       = 5'b00001,
		CPM_OP_STORE      = 5'b00010,
		CPM_OP_COPY       = 5'b00011,
		CPM_OP_ADD        = 5'b00100,
		CPM_OP_SUB        = 5'b00101,
		CPM_OP_CMP        = 5'b00110,
		CPM_OP_AND        = 5'b00111,
		CPM_OP_OR         = 5'b01000,
		CPM_OP_XOR        = 5'b01001,
		CPM_OP_INC        = 5'b01010,
		CPM_OP_DEC        = 5'b01011,
		CPM_OP_SHL        = 5'b01100,
		CPM_OP_SHR        = 5'b01101,
		CPM_OP_ROL        = 5'b01110,
		CPM_OP_ROR        = 5'b01111,
		CPM_OP_CARRY_ONE  = 5'b10000,
		CPM_OP_CARRY_ZERO = 5'b10001,
		CPM_OP_BIT_ONE    = 5'b10010,
		CPM_OP_BIT_ZERO   = 5'b10011,
		CPM_OP_BRANCH     = 5'b10100,
		CPM_OP_JUMP       = 5'b10101,
		CPM_OP_CALL_ABS   = 5'b10110,
		CPM_OP_CALL_REL   = 5'b10111,
		CPM_OP_RETURN     = 5'b11000,
		CPM_OP_SWAP_HIGH  = 5'b11001,
		CPM_OP_SWAP_LOW   = 5'b11010,
		CPM_OP_DEC_LOOP   = 5'b11011
	} cpm_op_t;

	typedef enum logic [2:0] {
		CPM_CC_ALWAYS       = 3'b000,
		CPM_CC_EQUAL        = 3'b001,
		CPM_CC_NOT_EQUAL    = 3'b010,
		CPM_CC_CARRY_ZERO   = 3'b011,
		CPM_CC_CARRY_ONE    = 3'b100
	} cpm_cond_t;

endpackage

// *** cpm_core_regs.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "cpm_map.svh"

// Overview of operation
// - 8-bit accumulator is the main data register, zero at reset.
// - 14-bit program counter steps by one on each instruction or operand fetch.
// - program counter comes out of reset at 3ffd.
// - jump, taken branch and return load a target instead of stepping.
// - both call forms save the return address in the 14-bit shadow register.
// - return copies the shadow register into the program counter.
// - shadow register comes out of reset at 3ffd.
// - two swaps exchange accumulator with shadow high part or low part.
// - two-bit flag register unreadable by program, reachable only via debug port.
// - reset clears zero and carry flags.
// - zero flag tracks zero result of load, store, move, arithmetic, logic, shifts.
// - add sets carry on unsigned overflow.
// - subtract or compare sets carry when memory operand exceeds register.
// - bit-test branches copy the tested bit into carry.
// - dedicated operations force carry to one or zero.
// - shifts and rotates are 9-bit through carry; rotates feed old carry in.
// - equal branches use only zero flag; carry branches use only carry.
// - accumulator and accumulator-with-memory operations except compare write the accumulator.
// - memory copy and decrement loop never read or change the accumulator.
// - data port, pointer and page select sit at 0e, 0f and 1f.
// - data port accesses go to the direct-page location held in the pointer.
// - page select picks which part of memory shows in window c0 to ff.
// - relative branch adds sign-extended 8-bit offset to the program counter.
module cpm_core_regs import cpm_pkg::*; #(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 8
) (
	// clock, reset, enable
	input  wire logic               clock_in,
	input  wire logic               resetn_in,
	input  wire logic               ce_in,
	// operation port from the sequencer
	input  wire logic               op_valid_in,
	input  wire cpm_op_t            op_in,
	input  wire cpm_cond_t          cond_in,
	input  wire logic [DATA_W-1:0]  operand_in,
	input  wire logic [DATA_W-1:0]  offset_in,
	input  wire logic [ADDR_W-1:0]  target_in,
	input  wire logic [2:0]         bit_sel_in,
	input  wire logic               fetch_in,
	// core data address translation
	input  wire logic [ADDR_W-1:0]  core_addr_in,
	output logic      [ADDR_W-1:0]  mem_addr_out,
	// register bus
	input  wire logic [7:0]         bus_addr_in,
	input  wire logic [DATA_W-1:0]  bus_wdata_in,
	input  wire logic               bus_wr_in,
	input  wire logic               bus_rd_in,
	output logic      [DATA_W-1:0]  bus_rdata_out,
	// pointed location access
	input  wire logic [DATA_W-1:0]  pointed_rdata_in,
	output logic      [ADDR_W-1:0]  pointed_addr_out,
	output logic      [DATA_W-1:0]  pointed_wdata_out,
	output logic                    pointed_wr_out,
	// memory result of store, copy and loop decrement
	output logic      [DATA_W-1:0]  result_out,
	output logic                    result_we_out,
	output logic                    taken_out,
	// debug access to internal state
	input  wire logic               dbg_flag_we_in,
	input  wire logic [1:0]         dbg_flag_in,
	output logic      [1:0]         flag_out,
	output logic      [DATA_W-1:0]  acc_out,
	output logic      [ADDR_W-1:0]  pc_out,
	output logic      [ADDR_W-1:0]  shadow_out
);

	if (ADDR_W != 14 || DATA_W != 8) begin : g_check
		$error("cpm_core_regs supports only 14-bit addresses and 8-bit data");
	end

	logic [DATA_W-1:0] acc;
	logic [ADDR_W-1:0] program_counter;
	logic [ADDR_W-1:0] shadow_return_register;
	logic              zero_flag;
	logic              carry_flag;
	logic [DATA_W-1:0] pointer_register;
	logic [DATA_W-1:0] page_window_select;

	logic [DATA_W-1:0] next_acc;
	logic              next_zero;
	logic              next_carry;
	logic [ADDR_W-1:0] next_pc;
	logic [ADDR_W-1:0] next_shadow;
	logic [DATA_W-1:0] next_result;
	logic              next_result_we;
	logic              next_taken;
	logic [DATA_W:0]   wide;
	logic [ADDR_W-1:0] rel_target;
	logic              exec;

	// maps a core address onto the pointed location or the page window
	function automatic logic [ADDR_W-1:0] cpm_xlate(
		input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] ptr,
		input logic [DATA_W-1:0] page
	);
		if (a == ADDR_W'(`CPM_OFS_POINTED_DATA))
			cpm_xlate = {`CPM_DIRECT_HI_ZERO, ptr};
		else if (a >= `CPM_WIN_LO && a <= `CPM_WIN_HI)
			cpm_xlate = {page, a[`CPM_WIN_OFS_W-1:0]};
		else
			cpm_xlate = a;
	endfunction

	function automatic logic cpm_cond_met(
		input cpm_cond_t c,
		input logic      z,
		input logic      cy
	);
		case (c)
			CPM_CC_ALWAYS:     cpm_cond_met = 1'b1;
			CPM_CC_EQUAL:      cpm_cond_met = z;
			CPM_CC_NOT_EQUAL:  cpm_cond_met = !z;
			CPM_CC_CARRY_ZERO: cpm_cond_met = !cy;
			CPM_CC_CARRY_ONE:  cpm_cond_met = cy;
			default:           cpm_cond_met = 1'b0;
		endcase
	endfunction

	assign exec = ce_in && op_valid_in;
	// relative target counts from the already stepped program counter
	assign rel_target = program_counter + {{(ADDR_W-DATA_W){offset_in[`CPM_SIGN_BIT]}}, offset_in};

	always_comb begin
		next_acc = acc;
		next_zero = zero_flag;
		next_carry = carry_flag;
		next_pc = fetch_in ? program_counter + ADDR_W'(1) : program_counter;
		next_shadow = shadow_return_register;
		next_result = result_out;
		next_result_we = 1'b0;
		next_taken = 1'b0;
		wide = '0;
		case (op_in)
			CPM_OP_LOAD: begin
				next_acc = operand_in;
				next_zero = (operand_in == `CPM_ZERO_BYTE);
			end
			CPM_OP_STORE: begin
				next_result = acc;
				next_result_we = 1'b1;
				next_zero = (acc == `CPM_ZERO_BYTE);
			end
			CPM_OP_COPY: begin
				next_result = operand_in;
				next_result_we = 1'b1;
				next_zero = (operand_in == `CPM_ZERO_BYTE);
			end
			CPM_OP_ADD: begin
				wide = {1'b0, acc} + {1'b0, operand_in};
				next_acc = wide[DATA_W-1:0];
				next_carry = wide[DATA_W];
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_SUB, CPM_OP_CMP: begin
				wide = {1'b0, acc} - {1'b0, operand_in};
				if (op_in == CPM_OP_SUB)
					next_acc = wide[DATA_W-1:0];
				next_carry = (operand_in > acc);
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_AND, CPM_OP_OR, CPM_OP_XOR: begin
				if (op_in == CPM_OP_AND)
					wide = {1'b0, acc & operand_in};
				else if (op_in == CPM_OP_OR)
					wide = {1'b0, acc | operand_in};
				else
					wide = {1'b0, acc ^ operand_in};
				next_acc = wide[DATA_W-1:0];
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_INC, CPM_OP_DEC: begin
				if (op_in == CPM_OP_INC)
					wide = {1'b0, acc + `CPM_ONE_BYTE};
				else
					wide = {1'b0, acc - `CPM_ONE_BYTE};
				next_acc = wide[DATA_W-1:0];
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_SHL, CPM_OP_ROL: begin
				// nine-bit view: carry takes the bit leaving the top
				wide = {acc, (op_in == CPM_OP_ROL) ? carry_flag : 1'b0};
				next_acc = wide[DATA_W-1:0];
				next_carry = wide[DATA_W];
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_SHR, CPM_OP_ROR: begin
				wide = {acc[0], (op_in == CPM_OP_ROR) ? carry_flag : 1'b0, acc[DATA_W-1:1]};
				next_acc = wide[DATA_W-1:0];
				next_carry = wide[DATA_W];
				next_zero = (wide[DATA_W-1:0] == `CPM_ZERO_BYTE);
			end
			CPM_OP_CARRY_ONE:  next_carry = 1'b1;
			CPM_OP_CARRY_ZERO: next_carry = 1'b0;
			CPM_OP_BIT_ONE, CPM_OP_BIT_ZERO: begin
				next_carry = operand_in[bit_sel_in];
				next_taken = operand_in[bit_sel_in] == (op_in == CPM_OP_BIT_ONE);
				if (next_taken)
					next_pc = rel_target;
			end
			CPM_OP_BRANCH: begin
				next_taken = cpm_cond_met(cond_in, zero_flag, carry_flag);
				if (next_taken)
					next_pc = rel_target;
			end
			CPM_OP_JUMP: begin
				next_pc = target_in;
				next_taken = 1'b1;
			end
			CPM_OP_CALL_ABS: begin
				next_shadow = program_counter;
				next_pc = target_in;
				next_taken = 1'b1;
			end
			CPM_OP_CALL_REL: begin
				next_shadow = program_counter;
				next_pc = rel_target;
				next_taken = 1'b1;
			end
			CPM_OP_RETURN: begin
				next_pc = shadow_return_register;
				next_taken = 1'b1;
			end
			CPM_OP_SWAP_HIGH: begin
				// only six bits of the high part exist; upper two read zero
				next_acc = DATA_W'(shadow_return_register[ADDR_W-1:DATA_W]);
				next_shadow = {acc[ADDR_W-DATA_W-1:0], shadow_return_register[DATA_W-1:0]};
			end
			CPM_OP_SWAP_LOW: begin
				next_acc = shadow_return_register[DATA_W-1:0];
				next_shadow = {shadow_return_register[ADDR_W-1:DATA_W], acc};
			end
			CPM_OP_DEC_LOOP: begin
				// loop counter lives in memory, accumulator untouched
				next_result = operand_in - `CPM_ONE_BYTE;
				next_result_we = 1'b1;
				next_taken = (operand_in != `CPM_ONE_BYTE);
				if (next_taken)
					next_pc = rel_target;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc <= `CPM_RST_ACC;
			program_counter <= `CPM_RST_PC;
			shadow_return_register <= `CPM_RST_SHADOW;
		end else if (exec) begin
			acc <= next_acc;
			program_counter <= next_pc;
			shadow_return_register <= next_shadow;
		end else if (ce_in && fetch_in) begin
			program_counter <= program_counter + ADDR_W'(1);
		end
	end

	// debug write loses to a same-cycle operation so results are never dropped
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			zero_flag <= `CPM_RST_FLAG;
			carry_flag <= `CPM_RST_FLAG;
		end else if (exec) begin
			zero_flag <= next_zero;
			carry_flag <= next_carry;
		end else if (ce_in && dbg_flag_we_in) begin
			zero_flag <= dbg_flag_in[`CPM_FLAG_Z];
			carry_flag <= dbg_flag_in[`CPM_FLAG_C];
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			result_out <= `CPM_ZERO_BYTE;
			result_we_out <= 1'b0;
			taken_out <= 1'b0;
		end else if (ce_in) begin
			result_out <= exec ? next_result : result_out;
			result_we_out <= exec && next_result_we;
			taken_out <= exec && next_taken;
		end
	end

	// mapped registers; flags deliberately have no bus address
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pointer_register <= `CPM_RST_POINTER;
			page_window_select <= `CPM_RST_PAGE;
		end else if (ce_in && bus_wr_in) begin
			if (bus_addr_in == `CPM_OFS_POINTER)
				pointer_register <= bus_wdata_in;
			if (bus_addr_in == `CPM_OFS_PAGE_SELECT)
				page_window_select <= bus_wdata_in;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus_rdata_out <= `CPM_ZERO_BYTE;
			pointed_wr_out <= 1'b0;
			pointed_wdata_out <= `CPM_ZERO_BYTE;
		end else if (ce_in) begin
			pointed_wr_out <= bus_wr_in && bus_addr_in == `CPM_OFS_POINTED_DATA;
			if (bus_wr_in && bus_addr_in == `CPM_OFS_POINTED_DATA)
				pointed_wdata_out <= bus_wdata_in;
			if (!bus_rd_in)
				bus_rdata_out <= `CPM_ZERO_BYTE;
			else if (bus_addr_in == `CPM_OFS_POINTED_DATA)
				bus_rdata_out <= pointed_rdata_in;
			else if (bus_addr_in == `CPM_OFS_POINTER)
				bus_rdata_out <= pointer_register;
			else if (bus_addr_in == `CPM_OFS_PAGE_SELECT)
				bus_rdata_out <= page_window_select;
			else
				bus_rdata_out <= `CPM_ZERO_BYTE;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_addr_out <= '0;
			pointed_addr_out <= '0;
		end else if (ce_in) begin
			mem_addr_out <= cpm_xlate(core_addr_in, pointer_register, page_window_select);
			pointed_addr_out <= cpm_xlate(ADDR_W'(`CPM_OFS_POINTED_DATA), next_ptr_view(), page_window_select);
		end
	end

	function automatic logic [DATA_W-1:0] next_ptr_view();
		next_ptr_view = (bus_wr_in && bus_addr_in == `CPM_OFS_POINTER) ? bus_wdata_in
			: pointer_register;
	endfunction

	assign acc_out = acc;
	assign pc_out = program_counter;
	assign shadow_out = shadow_return_register;
	assign flag_out = {zero_flag, carry_flag};

	property p_load_acc;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_LOAD |=> acc == $past(operand_in)
			&& zero_flag == ($past(operand_in) == `CPM_ZERO_BYTE);
	endproperty
	a_load_acc: assert property (p_load_acc) else $error("load result wrong");

	property p_fetch_step;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && fetch_in && !op_valid_in |=> program_counter == $past(program_counter) + 14'h1;
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("pc did not step");

	property p_call_return;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_CALL_ABS ##1 exec && op_in == CPM_OP_RETURN
			|=> program_counter == $past(program_counter, 2);
	endproperty
	a_call_return: assert property (p_call_return) else $error("return address lost");

	property p_add_carry;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_ADD |=> carry_flag ==
			(({1'b0, $past(acc)} + {1'b0, $past(operand_in)}) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_sub_borrow;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_CMP |=> carry_flag == ($past(operand_in) > $past(acc))
			&& $stable(acc);
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("compare borrow wrong");

	property p_bit_copy;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && (op_in == CPM_OP_BIT_ONE || op_in == CPM_OP_BIT_ZERO)
			|=> carry_flag == $past(operand_in[bit_sel_in]) && $stable(zero_flag);
	endproperty
	a_bit_copy: assert property (p_bit_copy) else $error("tested bit not in carry");

	property p_rotate_left;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_ROL |=> acc == {$past(acc[`CPM_SIGN_BIT-1:0]), $past(carry_flag)}
			&& carry_flag == $past(acc[`CPM_SIGN_BIT]);
	endproperty
	a_rotate_left: assert property (p_rotate_left) else $error("rotate wrong");

	property p_equal_branch;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && op_in == CPM_OP_BRANCH && cond_in == CPM_CC_EQUAL
			|=> taken_out == $past(zero_flag);
	endproperty
	a_equal_branch: assert property (p_equal_branch) else $error("equal branch wrong");

	property p_loop_keeps_acc;
		@(posedge clock_in) disable iff (!resetn_in)
		exec && (op_in == CPM_OP_DEC_LOOP || op_in == CPM_OP_COPY) |=> $stable(acc);
	endproperty
	a_loop_keeps_acc: assert property (p_loop_keeps_acc) else $error("acc disturbed");

	property p_window;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && core_addr_in >= `CPM_WIN_LO && core_addr_in <= `CPM_WIN_HI
			|=> mem_addr_out == {$past(page_window_select),
				$past(core_addr_in[`CPM_WIN_OFS_W-1:0])};
	endproperty
	a_window: assert property (p_window) else $error("window address wrong");

endmodule

// *** cpm_mem_model.sv ***
`timescale 1ns/1ps
module cpm_mem_model (
	// direct page memory behind the pointed port
	input  wire logic        clock_in,
	input  wire logic [13:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	output logic      [7:0]  rdata_out
);
	logic [7:0] mem [0:255];

	// unwritten cells hold the inverted address, so only cell ff starts at zero
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = ~8'(i);
		end
	end

	always @(posedge clock_in) begin
		if (wr_in) begin
			mem[addr_in[7:0]] <= wdata_in;
		end
	end

	// only the direct page can be pointed at, upper bits are ignored
	assign rdata_out = mem[addr_in[7:0]];
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top import cpm_pkg::*; ;
	logic        clock_in, resetn_in, ce, op_valid, fetch, b_wr, b_rd, d_we, p_wr, r_we, taken;
	cpm_op_t     op;
	cpm_cond_t   cond;
	logic [7:0]  operand, offset, b_addr, b_wd, b_rdata, p_rdata, p_wd, result, acc, rd;
	logic [2:0]  bsel;
	logic [1:0]  d_flag, flag;
	logic [13:0] target, c_addr, m_addr, p_addr, pc, shadow, epc;
	logic        tk;
	int          fail_count, checked, cycles;

	cpm_core_regs uut (
		.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce), .op_valid_in(op_valid),
		.op_in(op), .cond_in(cond), .operand_in(operand), .offset_in(offset),
		.target_in(target), .bit_sel_in(bsel), .fetch_in(fetch), .core_addr_in(c_addr),
		.mem_addr_out(m_addr), .bus_addr_in(b_addr), .bus_wdata_in(b_wd), .bus_wr_in(b_wr),
		.bus_rd_in(b_rd), .bus_rdata_out(b_rdata), .pointed_rdata_in(p_rdata),
		.pointed_addr_out(p_addr), .pointed_wdata_out(p_wd), .pointed_wr_out(p_wr),
		.result_out(result), .result_we_out(r_we), .taken_out(taken),
		.dbg_flag_we_in(d_we), .dbg_flag_in(d_flag), .flag_out(flag), .acc_out(acc),
		.pc_out(pc), .shadow_out(shadow)
	);

	cpm_mem_model mem (
		.clock_in(clock_in), .addr_in(p_addr), .wdata_in(p_wd), .wr_in(p_wr),
		.rdata_out(p_rdata)
	);

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// hang guard well above the roughly 140 cycles the tests need
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			close_out();
		end
	end

	function automatic logic [13:0] rel(input logic [13:0] p, input logic [7:0] o);
		return p + {{6{o[7]}}, o};
	endfunction

	task automatic do_op(input cpm_op_t o, input logic [7:0] v, input logic [7:0] off = 8'h00,
		input logic [13:0] t = 14'h0000, input cpm_cond_t c = CPM_CC_ALWAYS,
		input logic [2:0] b = 3'h0);
		@(posedge clock_in);
		op_valid <= 1'b1;
		op <= o;
		operand <= v;
		offset <= off;
		target <= t;
		cond <= c;
		bsel <= b;
		@(posedge clock_in);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		b_wr <= 1'b1;
		b_addr <= a;
		b_wd <= d;
		@(posedge clock_in);
		b_wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		b_rd <= 1'b1;
		b_addr <= a;
		@(posedge clock_in);
		b_rd <= 1'b0;
		#1;
		d = b_rdata;
	endtask

	task automatic xlate(input logic [13:0] a, input logic [13:0] exp);
		@(posedge clock_in);
		c_addr <= a;
		@(posedge clock_in);
		#1;
		chk("mem_addr", 16'(m_addr), 16'(exp));
	endtask

	task automatic t_reset();
		chk("acc", 16'(acc), 16'h0000);
		chk("pc", 16'(pc), 16'h3ffd);
		chk("shadow", 16'(shadow), 16'h3ffd);
		chk("flag", 16'(flag), 16'h0000);
		bus_read(8'h0f, rd);
		chk("pointer", 16'(rd), 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_fetch();
		@(posedge clock_in);
		fetch <= 1'b1;
		repeat (3) @(posedge clock_in);
		fetch <= 1'b0;
		#1;
		chk("pc wrap", 16'(pc), 16'h0000);
		// enable low must freeze the counter
		@(posedge clock_in);
		ce <= 1'b0;
		fetch <= 1'b1;
		repeat (2) @(posedge clock_in);
		ce <= 1'b1;
		fetch <= 1'b0;
		#1;
		chk("pc frozen", 16'(pc), 16'h0000);
		epc = 14'h0000;
		$display("test fetch done");
	endtask

	task automatic t_alu();
		do_op(CPM_OP_LOAD, 8'h00);
		chk("flag", 16'(flag), 16'h0002);
		do_op(CPM_OP_LOAD, 8'h80);
		do_op(CPM_OP_ADD, 8'h80);
		chk("acc", 16'(acc), 16'h0000);
		chk("flag", 16'(flag), 16'h0003);
		do_op(CPM_OP_LOAD, 8'h7f);
		do_op(CPM_OP_ADD, 8'h01);
		chk("flag", 16'(flag), 16'h0000);
		do_op(CPM_OP_LOAD, 8'hc0);
		do_op(CPM_OP_ADD, 8'h50);
		chk("flag", 16'(flag), 16'h0001);
		do_op(CPM_OP_SUB, 8'h20);
		chk("acc", 16'(acc), 16'h00f0);
		chk("flag", 16'(flag), 16'h0001);
		do_op(CPM_OP_CMP, 8'h10);
		chk("flag", 16'(flag), 16'h0000);
		do_op(CPM_OP_CMP, 8'hf0);
		chk("acc", 16'(acc), 16'h00f0);
		chk("flag", 16'(flag), 16'h0002);
		do_op(CPM_OP_INC, 8'h00);
		do_op(CPM_OP_OR, 8'h0e);
		chk("acc", 16'(acc), 16'h00ff);
		do_op(CPM_OP_XOR, 8'hff);
		chk("flag", 16'(flag), 16'h0002);
		do_op(CPM_OP_DEC, 8'h00);
		chk("dec", 16'({flag, acc}), 16'h00ff);
		$display("test alu done");
	endtask

	task automatic t_shift();
		do_op(CPM_OP_LOAD, 8'h81);
		do_op(CPM_OP_CARRY_ZERO, 8'h00);
		do_op(CPM_OP_SHL, 8'h00);
		chk("shl", 16'({flag, acc}), 16'h0102);
		do_op(CPM_OP_ROL, 8'h00);
		chk("rol", 16'({flag, acc}), 16'h0005);
		do_op(CPM_OP_SHR, 8'h00);
		chk("shr", 16'({flag, acc}), 16'h0102);
		do_op(CPM_OP_ROR, 8'h00);
		chk("ror", 16'({flag, acc}), 16'h0081);
		do_op(CPM_OP_CARRY_ONE, 8'h00);
		chk("flag", 16'(flag), 16'h0001);
		do_op(CPM_OP_AND, 8'h00);
		chk("flag", 16'(flag), 16'h0003);
		do_op(CPM_OP_CARRY_ZERO, 8'h00);
		chk("flag", 16'(flag), 16'h0002);
		$display("test shift done");
	endtask

	task automatic t_branch();
		for (int f = 0; f < 2; f++) begin
			if (f == 1) begin
				@(posedge clock_in);
				d_we <= 1'b1;
				d_flag <= 2'b01;
				@(posedge clock_in);
				d_we <= 1'b0;
				#1;
				chk("dbg flag", 16'(flag), 16'h0001);
			end
			for (int i = 0; i < 5; i++) begin
				tk = (i == 0) || (i == 1 && f == 0) || (i == 2 && f == 1) ||
					(i == 3 && f == 0) || (i == 4 && f == 1);
				do_op(CPM_OP_BRANCH, 8'h00, 8'hfe, 14'h0000, cpm_cond_t'(i));
				if (tk) begin
					epc = rel(epc, 8'hfe);
				end
				chk("branch pc", 16'(pc), 16'(epc));
				chk("taken", 16'(taken), 16'(tk));
			end
		end
		chk("flag kept", 16'(flag), 16'h0001);
		$display("test branch done");
	endtask

	task automatic t_flow();
		do_op(CPM_OP_JUMP, 8'h00, 8'h00, 14'h0123);
		chk("pc", 16'(pc), 16'h0123);
		do_op(CPM_OP_CALL_ABS, 8'h00, 8'h00, 14'h0200);
		chk("shadow", 16'(shadow), 16'h0123);
		chk("pc", 16'(pc), 16'h0200);
		do_op(CPM_OP_RETURN, 8'h00);
		chk("pc", 16'(pc), 16'h0123);
		// call straight into return, no idle cycle between
		@(posedge clock_in);
		op_valid <= 1'b1;
		op <= CPM_OP_CALL_ABS;
		target <= 14'h0300;
		@(posedge clock_in);
		op <= CPM_OP_RETURN;
		@(posedge clock_in);
		op_valid <= 1'b0;
		#1;
		chk("pc", 16'(pc), 16'h0123);
		chk("taken", 16'(taken), 16'h0001);
		do_op(CPM_OP_CALL_REL, 8'h00, 8'h10);
		chk("shadow", 16'(shadow), 16'h0123);
		chk("pc", 16'(pc), 16'h0133);
		do_op(CPM_OP_LOAD, 8'h3c);
		do_op(CPM_OP_SWAP_HIGH, 8'h00);
		chk("swap hi", 16'(acc), 16'h0001);
		chk("shadow", 16'(shadow), 16'h3c23);
		do_op(CPM_OP_SWAP_LOW, 8'h00);
		chk("swap lo", 16'(acc), 16'h0023);
		chk("shadow", 16'(shadow), 16'h3c01);
		$display("test flow done");
	endtask

	task automatic t_bits_mem();
		do_op(CPM_OP_BIT_ONE, 8'h04, 8'h02, 14'h0000, CPM_CC_ALWAYS, 3'h2);
		chk("bit carry", 16'({taken, flag[0]}), 16'h0003);
		chk("pc", 16'(pc), 16'h0135);
		do_op(CPM_OP_BIT_ZERO, 8'h04, 8'h02, 14'h0000, CPM_CC_ALWAYS, 3'h2);
		chk("bit carry", 16'({taken, flag[0]}), 16'h0001);
		do_op(CPM_OP_BIT_ONE, 8'hfb, 8'h02, 14'h0000, CPM_CC_ALWAYS, 3'h2);
		chk("bit carry", 16'({taken, flag[0]}), 16'h0000);
		do_op(CPM_OP_STORE, 8'h00);
		chk("store", 16'({r_we, result}), 16'h0123);
		do_op(CPM_OP_COPY, 8'h00);
		chk("copy", 16'({r_we, result, flag[1]}), 16'h0201);
		do_op(CPM_OP_DEC_LOOP, 8'h05, 8'h80);
		chk("loop", 16'({taken, r_we, result}), 16'h0304);
		chk("pc", 16'(pc), 16'h00b5);
		do_op(CPM_OP_DEC_LOOP, 8'h01, 8'h80);
		chk("loop end", 16'({taken, result}), 16'h0000);
		chk("acc kept", 16'(acc), 16'h0023);
		$display("test bits and memory done");
	endtask

	task automatic t_regs();
		bus_write(8'h0f, 8'h33);
		bus_read(8'h0f, rd);
		chk("pointer", 16'(rd), 16'h0033);
		chk("pointed addr", 16'(p_addr), 16'h0033);
		bus_write(8'h0e, 8'ha5);
		chk("pointed wr", 16'({p_wr, p_wd}), 16'h01a5);
		bus_read(8'h0e, rd);
		chk("pointed rd", 16'(rd), 16'h00a5);
		bus_write(8'h1f, 8'h05);
		bus_write(8'h10, 8'h77);
		bus_read(8'h10, rd);
		chk("unmapped", 16'(rd), 16'h0000);
		bus_read(8'h1f, rd);
		chk("page", 16'(rd), 16'h0005);
		xlate(14'h00c7, 14'h0147);
		xlate(14'h00ff, 14'h017f);
		xlate(14'h00bf, 14'h00bf);
		xlate(14'h000e, 14'h0033);
		$display("test registers done");
	endtask

	initial begin
		resetn_in = 1'b0;
		ce = 1'b1;
		op_valid = 1'b0;
		op = CPM_OP_NOP;
		cond = CPM_CC_ALWAYS;
		operand = 8'h00;
		offset = 8'h00;
		target = 14'h0000;
		bsel = 3'h0;
		fetch = 1'b0;
		c_addr = 14'h0000;
		b_addr = 8'h00;
		b_wd = 8'h00;
		b_wr = 1'b0;
		b_rd = 1'b0;
		d_we = 1'b0;
		d_flag = 2'b00;
		repeat (4) @(posedge clock_in);
		resetn_in <= 1'b1;
		#1;
		t_reset();
		t_fetch();
		t_alu();
		t_shift();
		t_branch();
		t_flow();
		t_bits_mem();
		t_regs();
		close_out();
	end
endmodule
